// ### core/can_encoder_position_messaging.sv
`timescale 1ns/1ps
// Message layer of the position encoder
module can_encoder_position_messaging (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic                      rx_valid,
  input  wire enc_msg_pkg::can_frame_type rx_frame,
  output logic                           tx_valid,
  input  wire logic                      tx_ready,
  output enc_msg_pkg::can_frame_type     tx_frame,
  input  wire logic [31:0]               position,
  input  wire logic                      position_fault,
  input  wire logic                      link_fault_pin,
  input  wire enc_msg_pkg::nv_cfg_type   nv_cfg,
  output logic                           nv_write,
  output enc_msg_pkg::nv_write_type      nv_data,
  output logic [3:0]                     baud_code,
  output logic                           soft_reset,
  output logic [7:0]                     status_byte
);
  import enc_msg_pkg::*;

  typedef enum logic [1:0] {IDLE, SEND} tx_state_type;

  typedef struct packed {
    // Transmit side
    tx_state_type     tx_st;
    can_frame_type    frame;
    logic             pend_reply;
    logic             pend_cyc;
    logic             pend_par;
    logic [7:0]       par_fsc;
    // Working configuration
    logic [15:0]      interval;
    logic [15:0]      window;
    logic [15:0]      delay;
    logic [7:0]       command;
    // Millisecond timers
    logic [16:0]      period_cnt;
    logic [16:0]      window_cnt;
    logic [16:0]      delay_cnt;
    logic             delay_run;
    logic             running;
    // Sticky status flags
    logic             sync_flag;
    logic             par_flag;
    logic             pos_flag;
    logic             com_flag;
    // Load state, identifiers and output pulses
    logic             loaded;
    logic [5:0][10:0] ids;
    logic             fallback;
    logic [3:0]       baud;
    logic             nv_wr;
    nv_write_type     nv_d;
    logic             sreset;
  } core_state_type;

  core_state_type state_ff;
  core_state_type nxt_state;
  logic           tick;
  logic           sync_hit;
  logic           link_fault;
  logic [7:0]     status;
  logic           window_expired;
  logic           req_hit;
  logic           setp_hit;

  // Stored identifier or its fallback
  function automatic logic [10:0] pick_id(input logic valid, input logic [10:0] stored,
                                          input logic [10:0] fallback);
    pick_id = valid ? stored : fallback;
  endfunction

  // Period in ms as a 17-bit count, zero means 65,536 ms
  function automatic logic [16:0] ms_count(input logic [15:0] v);
    ms_count = (v == 16'h0) ? 17'h10000 : {1'b0, v};
  endfunction

  // Position frame assembled in one go from one position sample
  function automatic can_frame_type pos_frame(input logic [10:0] id, input logic [7:0] function_select_code,
                                              input logic [7:0] st, input logic [31:0] pos);
    pos_frame.ident              = id;
    pos_frame.frame_length_field = LEN_POS;
    pos_frame.data               = '0;
    pos_frame.data[0]            = function_select_code;
    pos_frame.data[1]            = st;
    pos_frame.data[2]            = pos[7:0];
    pos_frame.data[3]            = pos[15:8];
    pos_frame.data[4]            = pos[23:16];
    pos_frame.data[5]            = pos[31:24];
  endfunction

  // Bit-rate code outside 1..8 cannot be used; 0 is not supported yet
  function automatic logic bad_baud(input logic [7:0] code);
    bad_baud = (code == 8'h0) || (code > {4'h0, BAUD_MAX});
  endfunction

  // Parameter answer: code echoed, then the status byte
  // Nothing follows the status, so the frame stays two bytes long
  function automatic can_frame_type par_frame(input logic [10:0] id, input logic [7:0] function_select_code,
                                              input logic [7:0] st);
    par_frame                    = '0;
    par_frame.ident              = id;
    par_frame.frame_length_field = LEN_PREP;
    par_frame.data[0]            = function_select_code;
    par_frame.data[1]            = st;
  endfunction

  // Frame offered on one of our receive identifiers
  // Shared by the sync, request and parameter decoders
  function automatic logic id_hit(input logic valid, input can_frame_type f,
                                  input logic [10:0] id);
    id_hit = valid && (f.ident == id);
  endfunction

  // Link fault pin crosses into the core clock
  pin_sync u_link_sync (
    .clock  (clock),
    .resetn (resetn),
    .din    (link_fault_pin),
    .dout   (link_fault)
  );

  // Common millisecond tick, realigned by sync
  ms_tick u_tick (
    .clock   (clock),
    .resetn  (resetn),
    .realign (sync_hit),
    .tick    (tick)
  );

  // Sync frame with code 00h on the sync identifier
  assign sync_hit = state_ff.loaded && id_hit(rx_valid, rx_frame, state_ff.ids[3])
                    && rx_frame.data[0] == FSC_POS;

  // Receive decode for requests and parameter frames
  assign req_hit  = id_hit(rx_valid, rx_frame, state_ff.ids[0]);
  assign setp_hit = id_hit(rx_valid, rx_frame, state_ff.ids[4]);

  // Status byte assembly
  always_comb begin
    status           = '0;
    status[ST_BUSY]  = position_fault;
    status[ST_SYNC]  = state_ff.sync_flag;
    status[ST_PAR]   = state_ff.par_flag;
    status[ST_POS]   = state_ff.pos_flag;
    status[ST_COM]   = state_ff.com_flag;
    status[ST_DEF]   = state_ff.fallback;
    status[ST_CYC]   = state_ff.running;
    status[ST_SMD]   = state_ff.command[CMD_SYNC];
  end

  // Sync window running out at this tick
  // Kept apart so a read-status in the same cycle cannot clear a fresh timeout
  always_comb begin
    window_expired = tick && state_ff.loaded && state_ff.running
                     && state_ff.command[CMD_SYNC] && state_ff.window_cnt <= 17'h1;
  end

  // Receive decode, timers and transmit sequencing
  always_comb begin
    nxt_state = state_ff;
    // Output pulses last one cycle
    nxt_state.nv_wr  = 1'b0;
    nxt_state.sreset = 1'b0;

    // Load stored configuration once after reset
    if (!state_ff.loaded) begin
      nxt_state.loaded   = 1'b1;
      nxt_state.interval = nv_cfg.periodic_interval;
      nxt_state.window   = nv_cfg.sync_window_time;
      nxt_state.delay    = nv_cfg.sync_start_delay;
      nxt_state.command  = nv_cfg.command;
      nxt_state.ids[0] = pick_id(nv_cfg.id_valid[0], nv_cfg.ids[0], ID_REQ_DEF);
      nxt_state.ids[1] = pick_id(nv_cfg.id_valid[1], nv_cfg.ids[1], ID_REPLY_DEF);
      nxt_state.ids[2] = pick_id(nv_cfg.id_valid[2], nv_cfg.ids[2], ID_CYC_DEF);
      nxt_state.ids[3] = pick_id(nv_cfg.id_valid[3], nv_cfg.ids[3], ID_SYNC_DEF);
      nxt_state.ids[4] = pick_id(nv_cfg.id_valid[4], nv_cfg.ids[4], ID_SETP_DEF);
      nxt_state.ids[5] = pick_id(nv_cfg.id_valid[5], nv_cfg.ids[5], ID_PREP_DEF);
      nxt_state.fallback = (nv_cfg.id_valid != 6'h3f);
      if (bad_baud({4'h0, nv_cfg.baud_code})) begin
        nxt_state.baud     = BAUD_DEF;
        nxt_state.fallback = 1'b1;
      end else begin
        nxt_state.baud = nv_cfg.baud_code;
      end
      nxt_state.running    = nv_cfg.command[CMD_PERIODIC] && !nv_cfg.command[CMD_START];
      nxt_state.period_cnt = ms_count(nv_cfg.periodic_interval);
      nxt_state.window_cnt = ms_count(nv_cfg.sync_window_time);
    end else begin

      // Millisecond timers on the common tick
      if (tick) begin
        if (state_ff.running) begin
          if (state_ff.period_cnt <= 17'h1) begin
            nxt_state.period_cnt = ms_count(state_ff.interval);
            nxt_state.pend_cyc   = 1'b1;
          end else begin
            nxt_state.period_cnt = state_ff.period_cnt - 17'h1;
          end
          if (state_ff.command[CMD_SYNC]) begin
            if (state_ff.window_cnt <= 17'h1) begin
              nxt_state.running   = 1'b0;
              nxt_state.sync_flag = 1'b1;
            end else begin
              nxt_state.window_cnt = state_ff.window_cnt - 17'h1;
            end
          end
        end
        if (state_ff.delay_run) begin
          if (state_ff.delay_cnt <= 17'h1) begin
            nxt_state.delay_run  = 1'b0;
            nxt_state.running    = 1'b1;
            nxt_state.period_cnt = ms_count(state_ff.interval);
            nxt_state.window_cnt = ms_count(state_ff.window);
          end else begin
            nxt_state.delay_cnt = state_ff.delay_cnt - 17'h1;
          end
        end
      end

      // Sync restarts the window and, when waiting to start, arms the start delay
      if (sync_hit) begin
        nxt_state.window_cnt = ms_count(state_ff.window);
        if (state_ff.command[CMD_PERIODIC] && state_ff.command[CMD_START]
            && !state_ff.running && !state_ff.delay_run) begin
          nxt_state.delay_run = 1'b1;
          nxt_state.delay_cnt = {1'b0, state_ff.delay} + 17'h1;
        end
      end

      // Position request
      if (req_hit) begin
        if (rx_frame.data[0] == FSC_POS && rx_frame.frame_length_field != 4'h0) begin
          nxt_state.pend_reply = 1'b1;
        end else begin
          nxt_state.pos_flag = 1'b1;
        end
      end

      // Parameter set
      if (setp_hit) begin
        nxt_state.pend_par = 1'b1;
        nxt_state.par_fsc  = rx_frame.data[0];
        unique case (rx_frame.data[0]) inside
          FSC_RESET: nxt_state.sreset = 1'b1;
          FSC_RDSTAT: begin
            nxt_state.sync_flag = 1'b0;
            nxt_state.par_flag  = 1'b0;
            nxt_state.pos_flag  = 1'b0;
            nxt_state.com_flag  = link_fault;
          end
          FSC_TIME_RAM: begin
            nxt_state.interval = {rx_frame.data[2], rx_frame.data[1]};
            nxt_state.window   = {rx_frame.data[4], rx_frame.data[3]};
            nxt_state.delay    = {rx_frame.data[6], rx_frame.data[5]};
          end
          FSC_CMD_RAM: begin
            nxt_state.command = rx_frame.data[1];
            nxt_state.running = rx_frame.data[1][CMD_PERIODIC]
                                && !rx_frame.data[1][CMD_START];
            nxt_state.delay_run  = 1'b0;
            nxt_state.period_cnt = ms_count(state_ff.interval);
            nxt_state.window_cnt = ms_count(state_ff.window);
          end
          [FSC_RD_LO:FSC_RD_HI]: ;
          [FSC_TIME_NV:FSC_BAUD_NV]: begin
            nxt_state.nv_wr = 1'b1;
            nxt_state.nv_d  = {rx_frame.data[0], rx_frame.data[1], rx_frame.data[2],
                               rx_frame.data[3], rx_frame.data[4], rx_frame.data[5],
                               rx_frame.data[6]};
            if (rx_frame.data[0] == FSC_BAUD_NV && bad_baud(rx_frame.data[1])) begin
              nxt_state.nv_wr    = 1'b0;
              nxt_state.par_flag = 1'b1;
            end
          end
          default: nxt_state.par_flag = 1'b1;
        endcase
      end

      // Timeout and link fault set their sticky flags; set wins over clear
      if (window_expired) begin
        nxt_state.sync_flag = 1'b1;
      end
      if (link_fault) begin
        nxt_state.com_flag = 1'b1;
      end
      if (req_hit && rx_frame.data[0] != FSC_POS) begin
        nxt_state.pos_flag = 1'b1;
      end

      // Transmit: reply first, then parameter answer, then periodic
      unique case (state_ff.tx_st)
        IDLE: begin
          if (state_ff.pend_reply) begin
            nxt_state.pend_reply = 1'b0;
            nxt_state.frame = pos_frame(state_ff.ids[1], FSC_POS, status, position);
            nxt_state.tx_st = SEND;
          end else if (state_ff.pend_par) begin
            nxt_state.pend_par = 1'b0;
            nxt_state.frame = par_frame(state_ff.ids[5], state_ff.par_fsc, status);
            nxt_state.tx_st = SEND;
          end else if (state_ff.pend_cyc) begin
            nxt_state.pend_cyc = 1'b0;
            nxt_state.frame = pos_frame(state_ff.ids[2], FSC_CYC, status, position);
            nxt_state.tx_st = SEND;
          end
        end
        SEND: begin
          if (tx_ready) begin
            nxt_state.tx_st = IDLE;
          end
        end
        default: nxt_state.tx_st = IDLE;
      endcase

      // A stopped periodic stream drops its pending frame
      if (!nxt_state.running) begin
        nxt_state.pend_cyc = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs
  // The offered frame stands until the node takes it
  assign tx_valid    = (state_ff.tx_st == SEND);
  assign tx_frame    = state_ff.frame;
  assign nv_write    = state_ff.nv_wr;
  assign nv_data     = state_ff.nv_d;
  assign baud_code   = state_ff.baud;
  assign soft_reset  = state_ff.sreset;
  assign status_byte = status;
endmodule // can_encoder_position_messaging

// ### core/enc_msg_pkg.sv
package enc_msg_pkg;

  localparam int unsigned CLOCK_HZ       = 100000000;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES    = CLOCK_HZ / 1000000 * TICK_PERIOD_US;

  // Identifier fallbacks
  localparam logic [10:0] ID_REQ_DEF   = 11'h200;
  localparam logic [10:0] ID_REPLY_DEF = 11'h280;
  localparam logic [10:0] ID_CYC_DEF   = 11'h180;
  localparam logic [10:0] ID_SYNC_DEF  = 11'h100;
  localparam logic [10:0] ID_SETP_DEF  = 11'h300;
  localparam logic [10:0] ID_PREP_DEF  = 11'h380;

  // Function select codes
  localparam logic [7:0] FSC_POS      = 8'h00;
  localparam logic [7:0] FSC_CYC      = 8'h30;
  localparam logic [7:0] FSC_RESET    = 8'h01;
  localparam logic [7:0] FSC_RDSTAT   = 8'h02;
  localparam logic [7:0] FSC_TIME_RAM = 8'h03;
  localparam logic [7:0] FSC_CMD_RAM  = 8'h04;
  localparam logic [7:0] FSC_RD_LO    = 8'h11;
  localparam logic [7:0] FSC_RD_HI    = 8'h19;
  localparam logic [7:0] FSC_TIME_NV  = 8'h21;
  localparam logic [7:0] FSC_CMD_NV   = 8'h22;
  localparam logic [7:0] FSC_ID_LO    = 8'h23;
  localparam logic [7:0] FSC_ID_HI    = 8'h28;
  localparam logic [7:0] FSC_BAUD_NV  = 8'h29;

  // Bit rate codes
  localparam logic [3:0] BAUD_DEF = 4'h1;
  localparam logic [3:0] BAUD_MAX = 4'h8;

  // Command byte positions
  localparam int unsigned CMD_PERIODIC = 0;
  localparam int unsigned CMD_SYNC     = 1;
  localparam int unsigned CMD_START    = 2;

  // Status byte positions
  localparam int unsigned ST_BUSY = 7;
  localparam int unsigned ST_SYNC = 6;
  localparam int unsigned ST_PAR  = 5;
  localparam int unsigned ST_POS  = 4;
  localparam int unsigned ST_COM  = 3;
  localparam int unsigned ST_DEF  = 2;
  localparam int unsigned ST_CYC  = 1;
  localparam int unsigned ST_SMD  = 0;

  // Frame lengths; only LEN_POS and LEN_PREP are sent
  localparam logic [3:0] LEN_POS  = 4'h6;
  localparam logic [3:0] LEN_PREP = 4'h2;
  localparam logic [3:0] LEN_RDBK = 4'h4;
  localparam logic [3:0] LEN_TIME = 4'h7;

  typedef struct packed {
    logic [10:0]     ident;
    logic [3:0]      frame_length_field;
    logic [7:0][7:0] data;
  } can_frame_type;

  // Stored (nonvolatile) configuration; valid bits mark defined identifiers
  typedef struct packed {
    logic [15:0]      periodic_interval;
    logic [15:0]      sync_window_time;
    logic [15:0]      sync_start_delay;
    logic [7:0]       command;
    logic [5:0]       id_valid;
    logic [5:0][10:0] ids;
    logic [3:0]       baud_code;
  } nv_cfg_type;

  typedef struct packed {
    logic [7:0] store_sel;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
  } nv_write_type;

endpackage

// ### core/ms_tick.sv
`timescale 1ns/1ps
// Millisecond time base; a realign request restarts the count
module ms_tick (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic realign,
  output logic      tick
);
  import enc_msg_pkg::*;

  typedef struct packed {
    logic [16:0] count;
    logic        tick;
  } tick_state_type;

  tick_state_type state_ff;
  tick_state_type nxt_state;

  // Count one millisecond of core clocks
  always_comb begin
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    if (realign) begin
      nxt_state.count = 17'h0;
      nxt_state.tick  = 1'b1;
    end else if (state_ff.count == 17'(TICK_CYCLES - 1)) begin
      nxt_state.count = 17'h0;
      nxt_state.tick  = 1'b1;
    end else begin
      nxt_state.count = state_ff.count + 17'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign tick = state_ff.tick;
endmodule // ms_tick

// ### core/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for an outside level
module pin_sync (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_type;

  sync_state_type state_ff;
  sync_state_type nxt_state;

  // Shift the level through two flops
  always_comb begin
    nxt_state.s1 = din;
    nxt_state.s2 = state_ff.s1;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign dout = state_ff.s2;
endmodule // pin_sync

// ### verif/enc_chk_monitor.sv
`timescale 1ns/1ps
// Port-level checks of the message layer
module enc_chk (
  input wire logic                       clock,
  input wire logic                       resetn,
  input wire logic                       rx_valid,
  input wire enc_msg_pkg::can_frame_type rx_frame,
  input wire logic                       tx_valid,
  input wire logic                       tx_ready,
  input wire enc_msg_pkg::can_frame_type tx_frame,
  input wire enc_msg_pkg::nv_cfg_type    nv_cfg,
  input wire logic                       nv_write,
  input wire logic [3:0]                 baud_code,
  input wire logic [7:0]                 status_byte
);
  import enc_msg_pkg::*;
  logic [10:0] req_id, rep_id, setp_id, prep_id;
  logic        fresh;
  // Identifiers in force: stored where defined, else fallback
  assign req_id  = nv_cfg.id_valid[0] ? nv_cfg.ids[0] : ID_REQ_DEF;
  assign rep_id  = nv_cfg.id_valid[1] ? nv_cfg.ids[1] : ID_REPLY_DEF;
  assign setp_id = nv_cfg.id_valid[4] ? nv_cfg.ids[4] : ID_SETP_DEF;
  assign prep_id = nv_cfg.id_valid[5] ? nv_cfg.ids[5] : ID_PREP_DEF;
  // Request arriving while the transmit side is idle
  assign fresh   = rx_valid && !tx_valid;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_poll_answer:
  assert property (fresh && rx_frame.ident == req_id && rx_frame.data[0] == FSC_POS
    && !$past(rx_valid) |-> ##2 tx_valid && tx_frame.ident == rep_id) else $error("no reply");
  a_reply_shape:
  assert property (tx_valid && tx_frame.ident == rep_id |-> tx_frame.data[0] == FSC_POS
    && tx_frame.frame_length_field == LEN_POS) else $error("bad reply frame");
  a_frame_holds:
  assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("frame not held");
  a_gap_after:
  assert property (tx_valid && tx_ready |=> !tx_valid) else $error("no idle gap");
  a_param_answer:
  assert property (fresh && rx_frame.ident == setp_id && !$past(rx_valid) |-> ##2 tx_valid
    && tx_frame.ident == prep_id && tx_frame.frame_length_field == LEN_PREP
    && tx_frame.data[0] == $past(rx_frame.data[0], 2)) else $error("no param answer");
  a_store_pulse:
  assert property (rx_valid && rx_frame.ident == setp_id && rx_frame.data[0] == FSC_TIME_NV
    |-> ##[1:2] nv_write) else $error("no store pulse");
  a_baud_load:
  assert property ($past(resetn, 2) |-> baud_code == ((nv_cfg.baud_code inside {[1:8]})
    ? nv_cfg.baud_code : BAUD_DEF)) else $error("bad bit rate");
  a_fallback_bit:
  assert property ($past(resetn, 2) |-> status_byte[ST_DEF] == ((nv_cfg.id_valid != 6'h3f)
    || !(nv_cfg.baud_code inside {[1:8]})))
    else $error("bad fallback bit");
endmodule // enc_chk

bind can_encoder_position_messaging enc_chk u_enc_chk (.clock, .resetn, .rx_valid,
  .rx_frame, .tx_valid, .tx_ready, .tx_frame, .nv_cfg, .nv_write, .baud_code, .status_byte);

// ### verif/can_node.sv
`timescale 1ns/1ps
// Controlling node: sends frames and takes encoder frames after a set stall
module can_node (
  input  wire logic                       clock,
  output logic                            rx_valid,
  output enc_msg_pkg::can_frame_type      rx_frame,
  input  wire logic                       tx_valid,
  input  wire enc_msg_pkg::can_frame_type tx_frame,
  output logic                            tx_ready
);
  import enc_msg_pkg::*;
  int            stall = 0;
  int            waited = 0;
  can_frame_type got[$];
  // Idle at start
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_ready = 1'b0;
  end
  // One frame for one cycle, then the released lines carry the inverse
  task automatic send(input logic [10:0] id, input logic [3:0] len, input logic [63:0] b);
    @(posedge clock);
    rx_frame <= {id, len, b};
    rx_valid <= 1'b1;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_frame <= ~{id, len, b};
  endtask
  // Take each offered frame once the stall has run out
  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_frame);
      waited <= 0;
    end else if (tx_valid) begin
      waited <= waited + 1;
    end
    tx_ready <= tx_valid && !tx_ready && waited >= stall;
  end
endmodule // can_node

// ### verif/test_can_encoder_position_messaging.sv
`timescale 1ns/1ps
// Self-checking bench for the message layer
module test_can_encoder_position_messaging;
  import enc_msg_pkg::*;
  logic          clock, resetn, rx_valid, tx_valid, tx_ready, position_fault, link_fault_pin;
  logic          nv_write, soft_reset;
  logic [31:0]   position;
  logic [3:0]    baud_code;
  logic [7:0]    status_byte;
  can_frame_type rx_frame, tx_frame, fr;
  nv_cfg_type    nv_cfg, c;
  nv_write_type  nv_data;
  int            num_errors = 0;
  int            tests_run = 0;
  int            n;

  can_encoder_position_messaging u_can_encoder_position_messaging (.clock, .resetn,
    .rx_valid, .rx_frame, .tx_valid, .tx_ready, .tx_frame, .position, .position_fault,
    .link_fault_pin, .nv_cfg, .nv_write, .nv_data, .baud_code, .soft_reset, .status_byte);
  can_node u_can_node (.clock, .rx_valid, .rx_frame, .tx_valid, .tx_frame, .tx_ready);

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Compare one value and count it
  task automatic check(input string what, input logic [62:0] seen, input logic [62:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Print the counts and the verdict, then end the run
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Identifier, length and first six bytes of a frame
  function automatic logic [62:0] key(input can_frame_type f);
    return {f.ident, f.frame_length_field, f.data[5:0]};
  endfunction
  // Next taken frame, unknown if none arrives in time
  task automatic take(input int lim);
    for (n = 0; n < lim && u_can_node.got.size() == 0; n++) @(negedge clock);
    fr = u_can_node.got.size() ? u_can_node.got.pop_front() : 'x;
  endtask
  // Parameter answer echoes the code on the answer identifier
  task automatic answer(input logic [7:0] code);
    take(50);
    check("answer", {fr.ident, fr.frame_length_field, fr.data[0]}, {ID_PREP_DEF, LEN_PREP, code});
  endtask
  // Reset with a given stored configuration
  task automatic restart(input nv_cfg_type cf);
    @(posedge clock);
    resetn <= 1'b0;
    nv_cfg <= cf;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  // Long request, stalled take, sensor moving while the reply stands
  task automatic s_poll();
    u_can_node.stall = 3;
    @(posedge clock);
    position <= 32'h89abcdef;
    u_can_node.send(ID_REQ_DEF, 4'h8, 64'h5a5a_5a5a_5a5a_5a00);
    for (n = 0; n < 10 && !tx_valid; n++) @(negedge clock);
    @(posedge clock);
    position <= 32'h0;
    take(20);
    check("poll", key(fr), {ID_REPLY_DEF, LEN_POS, 32'h89abcdef, 8'h04, FSC_POS});
    u_can_node.stall = 0;
  endtask
  // Error flags, busy, and read-status clearing
  task automatic s_flags();
    @(posedge clock);
    position_fault <= 1'b1;
    link_fault_pin <= 1'b1;
    u_can_node.send(ID_REQ_DEF, 4'h1, 64'h05);
    repeat (4) @(posedge clock);
    u_can_node.send(ID_SETP_DEF, 4'h1, 64'h3f);
    repeat (8) @(negedge clock);
    check("flags", status_byte, 8'hbc);
    u_can_node.got.delete();
    u_can_node.send(ID_SETP_DEF, 4'h1, 64'h02);
    answer(FSC_RDSTAT);
    check("kept", status_byte, 8'h8c);
    @(posedge clock);
    position_fault <= 1'b0;
    link_fault_pin <= 1'b0;
    repeat (4) @(posedge clock);
    u_can_node.send(ID_SETP_DEF, 4'h1, 64'h02);
    answer(FSC_RDSTAT);
    check("cleared", status_byte, 8'h04);
  endtask
  // Persistent cycle-time store and software reset
  task automatic s_store();
    u_can_node.send(ID_SETP_DEF, 4'h7, 64'h0007_0605_0403_0221);
    for (n = 0; n < 10 && !nv_write; n++) @(negedge clock);
    check("store pulse", nv_write, 1'b1);
    check("store", nv_data, 56'h21_0203_0405_0607);
    answer(FSC_TIME_NV);
    u_can_node.send(ID_SETP_DEF, 4'h1, 64'h01);
    for (n = 0; n < 10 && !soft_reset; n++) @(negedge clock);
    check("soft", soft_reset, 1'b1);
    answer(FSC_RESET);
  endtask
  // Stored reply identifier, bit rate and periodic sending after a restart
  task automatic s_periodic();
    c = '0;
    c.periodic_interval = 16'h0001;
    c.command = 8'h01;
    c.id_valid = 6'h02;
    c.ids[1] = 11'h123;
    c.baud_code = 4'h5;
    restart(c);
    check("baud", baud_code, 4'h5);
    @(posedge clock);
    position <= 32'h01020304;
    u_can_node.send(ID_REQ_DEF, 4'h1, 64'h0);
    take(20);
    check("stored id", key(fr), {11'h123, LEN_POS, 32'h01020304, 8'h06, FSC_POS});
    u_can_node.send(ID_SYNC_DEF, 4'h1, 64'h0);
    take(1000);
    check("cyclic", key(fr), {ID_CYC_DEF, LEN_POS, 32'h01020304, 8'h06, FSC_CYC});
  endtask
  // Main sequence
  initial begin
    resetn = 1'b0;
    position = '0;
    position_fault = 1'b0;
    link_fault_pin = 1'b0;
    nv_cfg = '0;
    restart('0);
    check("default baud", baud_code, BAUD_DEF);
    s_poll();
    s_flags();
    s_store();
    s_periodic();
    stop_test();
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    stop_test();
  end
endmodule // test_can_encoder_position_messaging
